// ### shared/dp_host_defs.svh
/*
  Timing and field constants for the dual-port memory port controller.
  Assumes a 50 MHz core clock; counts derive from nanosecond figures.
*/
`ifndef DP_HOST_DEFS_SVH
`define DP_HOST_DEFS_SVH

`define CLK_PERIOD_NS 20
// Slowest-grade minimum figures in ns
`define T_PWE_NS 35
`define T_HZWE_NS 25
`define T_SD_NS 20
`define T_SLAVE_HOLD_NS 40
`define T_SWRD_NS 15
`define T_AA_NS 55
`define T_SAA_NS 55
// Cycle counts: minimums round up, never below one
`define CYC_UP(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? \
  1 : (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define PULSE_PLAIN_CYC `CYC_UP(`T_PWE_NS)
`define PULSE_OE_CYC `CYC_UP(`T_HZWE_NS + `T_SD_NS)
`define SLAVE_HOLD_CYC `CYC_UP(`T_SLAVE_HOLD_NS)
`define SWRD_CYC `CYC_UP(`T_SWRD_NS)
`define ACCESS_CYC `CYC_UP(`T_AA_NS)
`define SEM_ACCESS_CYC `CYC_UP(`T_SAA_NS)
`define ADDR_W 13
`define DATA_W 16
`define SEM_ADDR_W 3
`define CNT_W 4
`define CNT_ZERO 4'h0

`endif

// ### shared/dp_host_pkg.sv
/*
  Types for the dual-port memory port controller.
  Assumes dp_host_defs.svh is on the include path.
*/
`default_nettype none
`include "dp_host_defs.svh"
package dp_host_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_SETUP = 7'b000_0010,
    ST_STROBE = 7'b000_0100,
    ST_RELEASE = 7'b000_1000,
    ST_READ = 7'b001_0000,
    ST_SWRD = 7'b010_0000,
    ST_WAIT_BUSY = 7'b100_0000
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [`CNT_W-1:0] cnt;
    logic is_write;
    logic is_sem;
    logic sem_read_back;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [1:0] lanes_n;
    logic ce_n;
    logic sem_n;
    logic rw_n;
    logic oe_n;
    logic drive_n;
    logic done;
    logic [`DATA_W-1:0] rdata;
    logic token_held;
  } host_s;
endpackage
`default_nettype wire

// ### verilog/dp_port_host.sv
/*
  One port's host controller for an asynchronous dual-port memory with
  token latches and busy arbitration: memory read/write, token take and
  release. Assumes pins synchronous to core_clk; the memory sits outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dp_host_defs.svh"

module dp_port_host (
  input wire logic core_clk,
  input wire logic rst,
  // User command side
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_sem,
  input wire logic req_oe_low_write,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [`DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes_n,
  output logic rsp_valid,
  output logic [`DATA_W-1:0] rsp_rdata,
  output logic token_held,
  // Memory port pins
  output logic [`ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_sem_n,
  output logic mem_rw_n,
  output logic mem_oe_n,
  output logic upper_lane_n,
  output logic lower_lane_n,
  input wire logic [`DATA_W-1:0] mem_data_in,
  output logic [`DATA_W-1:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic mem_busy_n
);
  import dp_host_pkg::*;

  host_s cur_reg;
  host_s cur_next;

  // ==========================================================
  // Outputs straight from the state flops, except req_ready, decoded from the state
  // so no pin can glitch between edges
  assign req_ready = (cur_reg.state == ST_IDLE);
  assign rsp_valid = cur_reg.done;
  assign rsp_rdata = cur_reg.rdata;
  assign token_held = cur_reg.token_held;
  assign mem_addr = cur_reg.addr;
  assign mem_ce_n = cur_reg.ce_n;
  assign mem_sem_n = cur_reg.sem_n;
  assign mem_rw_n = cur_reg.rw_n;
  assign mem_oe_n = cur_reg.oe_n;
  assign {upper_lane_n, lower_lane_n} = cur_reg.lanes_n;
  assign mem_data_out = cur_reg.wdata;
  assign mem_data_oe_n = cur_reg.drive_n;

  // ==========================================================
  // Sequencer
  // Every pin moves on a clock edge only, so each device figure is
  // rounded up to whole cycles; this costs latency on fast grades but
  // one build serves every grade of part
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    if (cur_reg.cnt != `CNT_ZERO) begin
      cur_next.cnt = cur_reg.cnt - 1'b1;
    end
    case (cur_reg.state)
      ST_IDLE: begin
        if (req_valid) begin
          // Address set up with strobe high, before any select
          cur_next.addr = req_addr;
          cur_next.wdata = req_wdata;
          cur_next.is_write = req_write;
          cur_next.is_sem = req_sem;
          cur_next.sem_read_back = 1'b0;
          // Token cycles need a byte lane open or the write is dropped; open the low one
          cur_next.lanes_n = req_sem ? {req_lanes_n[1], 1'b0}
                                     : req_lanes_n;
          cur_next.oe_n = req_write ? ~req_oe_low_write : 1'b1;
          cur_next.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Select the array or a token latch, never both
        cur_next.ce_n = cur_reg.is_sem;
        cur_next.sem_n = ~cur_reg.is_sem;
        if (cur_reg.is_write) begin
          // Slave port: hold the strobe off while busy is low
          if (!mem_busy_n) begin
            cur_next.state = ST_WAIT_BUSY;
            cur_next.cnt = `CNT_W'(`SLAVE_HOLD_CYC);
          end else begin
            // Strobe falls on the same edge as select (select already low on a retry): device stays high-Z
            cur_next.rw_n = 1'b0;
            cur_next.drive_n = 1'b0;
            // Wider pulse when output enable is low, for turn-off
            cur_next.cnt = cur_reg.oe_n ? `CNT_W'(`PULSE_PLAIN_CYC)
                                        : `CNT_W'(`PULSE_OE_CYC);
            cur_next.state = ST_STROBE;
          end
        end else begin
          cur_next.oe_n = 1'b0;
          cur_next.cnt = cur_reg.is_sem ? `CNT_W'(`SEM_ACCESS_CYC)
                                        : `CNT_W'(`ACCESS_CYC);
          cur_next.state = ST_READ;
        end
      end
      ST_WAIT_BUSY: begin
        // Restart the hold whenever busy is low again
        if (!mem_busy_n) begin
          // Select stays low here so the device keeps reporting the clash
          cur_next.cnt = `CNT_W'(`SLAVE_HOLD_CYC);
        end else if (cur_reg.cnt == `CNT_ZERO) begin
          cur_next.state = ST_SETUP;
        end
      end
      ST_STROBE: begin
        // Busy during the pulse: lift the strobe at once, retry later.
        // A clocked host sees busy one edge late; the device blocks the
        // write on its own side, so the cut pulse is harmless
        if (!mem_busy_n) begin
          cur_next.rw_n = 1'b1;
          cur_next.drive_n = 1'b1;
          cur_next.cnt = `CNT_W'(`SLAVE_HOLD_CYC);
          cur_next.state = ST_WAIT_BUSY;
        end else if (cur_reg.cnt == `CNT_ZERO) begin
          // Strobe rises first; data held one more cycle
          cur_next.rw_n = 1'b1;
          // Output enable lifts with the strobe, so the device never turns
          // its drivers on while our data is still on the pins
          cur_next.oe_n = 1'b1;
          cur_next.state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        cur_next.ce_n = 1'b1;
        cur_next.sem_n = 1'b1;
        cur_next.drive_n = 1'b1;
        cur_next.oe_n = 1'b1;
        if (cur_reg.is_sem) begin
          // Token write: bit 0 low asks, high gives back
          if (cur_reg.wdata[0]) begin
            cur_next.token_held = 1'b0;
            cur_next.done = 1'b1;
            cur_next.state = ST_IDLE;
          end else begin
            cur_next.cnt = `CNT_W'(`SWRD_CYC);
            cur_next.state = ST_SWRD;
          end
        end else begin
          cur_next.done = 1'b1;
          cur_next.state = ST_IDLE;
        end
      end
      ST_SWRD: begin
        // Read the latch back only after the write-to-read gap
        if (cur_reg.cnt == `CNT_ZERO) begin
          cur_next.is_write = 1'b0;
          cur_next.sem_read_back = 1'b1;
          cur_next.state = ST_SETUP;
        end
      end
      ST_READ: begin
        // Sampling after full access time also covers busy-to-data delay
        if (cur_reg.cnt == `CNT_ZERO) begin
          cur_next.rdata = mem_data_in;
          if (cur_reg.sem_read_back) begin
            // Low read back means this port won the token
            cur_next.token_held = ~mem_data_in[0];
          end
          cur_next.ce_n = 1'b1;
          cur_next.sem_n = 1'b1;
          cur_next.oe_n = 1'b1;
          cur_next.done = 1'b1;
          cur_next.state = ST_IDLE;
        end
      end
      default: begin
        cur_next.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register; all control pins idle high under reset, address and data zero
  // Reset loads constants only, so the pins are clean from time zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= '{state: ST_IDLE, cnt: `CNT_ZERO, is_write: 1'b0,
        is_sem: 1'b0, sem_read_back: 1'b0, addr: '0, wdata: '0,
        lanes_n: 2'h3, ce_n: 1'b1, sem_n: 1'b1, rw_n: 1'b1,
        oe_n: 1'b1, drive_n: 1'b1, done: 1'b0, rdata: '0,
        token_held: 1'b0};
    end else begin
      cur_reg <= cur_next;
    end
  end
endmodule
`default_nettype wire

// ### testbench/dp_port_monitor.sv
/* Pin discipline checker for one memory port controller.
   Assumes a bind onto dp_port_host from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
`include "dp_host_defs.svh"
module dp_port_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_sem_n,
  input wire logic mem_rw_n,
  input wire logic mem_oe_n,
  input wire logic mem_data_oe_n,
  input wire logic mem_busy_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // Strobe steps; busy may cut a pulse short
  sequence strobe_on;
    !mem_rw_n || !mem_busy_n;
  endsequence
  // ==========
  // Select and strobe discipline
  select_one_a: assert property (mem_ce_n || mem_sem_n)
    else $error("both selects low");
  addr_steady_a: assert property (!mem_rw_n |-> $stable(mem_addr))
    else $error("address moved under strobe");
  write_select_a: assert property (!mem_rw_n |-> !(mem_ce_n && mem_sem_n))
    else $error("strobe without select");
  pulse_width_a: assert property ($fell(mem_rw_n) |-> ##1 strobe_on)
    else $error("write pulse too short");
  oe_pulse_a: assert property ($fell(mem_rw_n) && !mem_oe_n |->
    ##1 strobe_on ##1 strobe_on) else $error("oe low pulse too short");
  // ==========
  // Busy handling: strobe withdrawn, then held high 40 ns
  busy_stops_a: assert property (!mem_busy_n [*2] |-> mem_rw_n)
    else $error("strobe low under busy");
  busy_hold_a: assert property ($rose(mem_busy_n) |-> mem_rw_n [*3])
    else $error("strobe too soon after busy");
  // Data turnaround and token write-to-read gap
  turn_around_a: assert property (!mem_data_oe_n |->
    mem_oe_n || !mem_rw_n) else $error("bus fight");
  token_gap_a: assert property ($rose(mem_rw_n) && !mem_sem_n |=>
    mem_sem_n [*2]) else $error("token read too early");
endmodule
`default_nettype wire

// ### testbench/dp_mem_model.sv
/* Behavioural dual-port memory seen from one port, with token latches.
   Assumes the bench plays the other port via contend and other_owns. */
`timescale 1ns/10ps
`default_nettype none
`include "dp_host_defs.svh"
module dp_mem_model (
  input wire logic [`ADDR_W-1:0] mem_addr,
  input wire logic mem_ce_n,
  input wire logic mem_sem_n,
  input wire logic mem_rw_n,
  input wire logic mem_oe_n,
  input wire logic upper_lane_n,
  input wire logic lower_lane_n,
  input wire logic [`DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe_n,
  output logic [`DATA_W-1:0] mem_data_in,
  output logic mem_busy_n,
  input wire logic contend,
  input wire logic [7:0] other_owns
);
  logic [`DATA_W-1:0] ram [0:255];
  logic [`DATA_W-1:0] wd, last;
  logic [7:0] mine;
  logic sel, wr_on, rd_on;
  logic mbox_flag_n;
  localparam logic [7:0] MBOX_ADDR = 8'hff;
  initial mine = 8'h00;
  initial mbox_flag_n = 1'b1;
  assign sel = !mem_ce_n || !mem_sem_n;
  assign wr_on = sel && !mem_rw_n;
  assign rd_on = sel && mem_rw_n && !mem_oe_n;
  // ==========
  // Other port on the same address; one side only
  assign #15 mem_busy_n = !(contend && !mem_ce_n);
  // Reads; released bus shows the inverse, never a stale value
  always @* if (rd_on) last = !mem_ce_n ? ram[mem_addr[7:0]] :
    {15'h7fff, !mine[mem_addr[2:0]]};
  assign #15 mem_data_in = rd_on ? last : ~last;
  // Write lands at end of overlap, lost if busy blocked it
  always @* if (wr_on && !mem_data_oe_n) wd = mem_data_out;
  always @(negedge wr_on) if (mem_busy_n) begin
    if (!mem_ce_n && !upper_lane_n) ram[mem_addr[7:0]][15:8] = wd[15:8];
    if (!mem_ce_n && !lower_lane_n) ram[mem_addr[7:0]][7:0] = wd[7:0];
    if (!mem_sem_n && (!upper_lane_n || !lower_lane_n) &&
        !other_owns[mem_addr[2:0]]) begin
      mine[mem_addr[2:0]] = !wd[0];
    end
  end
  // ==========
  // Mailbox flag on the top word; one port plays both sides here, so its
  // write sets the flag and its read clears it, timed from the last enable
  always @(posedge wr_on or posedge rd_on) begin
    if (!mem_ce_n && mem_addr[7:0] == MBOX_ADDR) begin
      mbox_flag_n <= #15 !wr_on;
    end
  end
endmodule
`default_nettype wire

// ### testbench/dual_port_arbitration_semaphore_tb.sv
/* Self-checking bench for the port controller and a memory model.
   Assumes the model answers well inside the controller's counts. */
`timescale 1ns/10ps
`default_nettype none
`include "dp_host_defs.svh"
module dual_port_arbitration_semaphore_tb;
  logic core_clk, rst, req_valid, req_ready, req_write, req_sem;
  logic req_oe_low_write, rsp_valid, token_held, mem_ce_n, mem_sem_n;
  logic mem_rw_n, mem_oe_n, upper_lane_n, lower_lane_n, mem_data_oe_n;
  logic mem_busy_n, contend;
  logic [`ADDR_W-1:0] req_addr, mem_addr;
  logic [`DATA_W-1:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out;
  logic [1:0] req_lanes_n;
  logic [7:0] other_owns;
  int bad_count, comparisons;
  dp_port_host dut (.core_clk, .rst, .req_valid, .req_ready, .req_write,
    .req_sem, .req_oe_low_write, .req_addr, .req_wdata, .req_lanes_n,
    .rsp_valid, .rsp_rdata, .token_held, .mem_addr, .mem_ce_n, .mem_sem_n,
    .mem_rw_n, .mem_oe_n, .upper_lane_n, .lower_lane_n, .mem_data_in,
    .mem_data_out, .mem_data_oe_n, .mem_busy_n);
  dp_mem_model mem (.mem_addr, .mem_ce_n, .mem_sem_n, .mem_rw_n, .mem_oe_n,
    .upper_lane_n, .lower_lane_n, .mem_data_out, .mem_data_oe_n,
    .mem_data_in, .mem_busy_n, .contend, .other_owns);
  // ==========
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command, then a bounded wait for its response pulse
  task automatic cmd(logic [2:0] kind, logic [12:0] a, logic [15:0] d,
      logic [1:0] ln);
    int n;
    @(posedge core_clk);
    #2 {req_write, req_sem, req_oe_low_write} = kind;
    {req_addr, req_wdata, req_lanes_n, req_valid} = {a, d, ln, 1'b1};
    @(posedge core_clk);
    #2 req_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1; n++) begin
      if (n == 60) begin
        bad_count++;
        wrap_up();
      end
      @(posedge core_clk);
      #2;
    end
  endtask
  // ==========
  // Back to back writes, byte lane merge with output enable low
  task automatic t_array();
    cmd(3'b100, 13'h0012, 16'ha5c3, 2'b00);
    cmd(3'b100, 13'h0013, 16'h1234, 2'b00);
    cmd(3'b101, 13'h0012, 16'hff00, 2'b01);
    cmd(3'b000, 13'h0012, 16'h0000, 2'b00);
    chk("merged word", 16'hffc3, rsp_rdata);
    chk("mailbox idle", 16'h0001, {15'h0000, mem.mbox_flag_n});
    cmd(3'b100, 13'h00ff, 16'h0001, 2'b00);
    chk("mailbox set", 16'h0000, {15'h0000, mem.mbox_flag_n});
    cmd(3'b000, 13'h00ff, 16'h0000, 2'b00);
    chk("mailbox word", 16'h0001, rsp_rdata);
    chk("mailbox clear", 16'h0001, {15'h0000, mem.mbox_flag_n});
  endtask
  // Token take, release, and a take refused by the other port
  task automatic t_token();
    cmd(3'b110, 13'h0003, 16'h0000, 2'b11);
    chk("token read", 16'hfffe, rsp_rdata);
    chk("token taken", 16'h0001, {15'h0000, token_held});
    cmd(3'b010, 13'h0003, 16'h0000, 2'b11);
    chk("token peek", 16'hfffe, rsp_rdata);
    chk("peek keeps", 16'h0001, {15'h0000, token_held});
    cmd(3'b110, 13'h0003, 16'h0001, 2'b11);
    chk("token freed", 16'h0000, {15'h0000, token_held});
    cmd(3'b010, 13'h0003, 16'h0000, 2'b11);
    chk("free latch", 16'hffff, rsp_rdata);
    cmd(3'b110, 13'h0005, 16'h0000, 2'b11);
    chk("token refused", 16'h0000, {15'h0000, token_held});
    chk("refused read", 16'hffff, rsp_rdata);
  endtask
  // Write stalled by busy, reissued after release
  task automatic t_busy();
    contend = 1'b1;
    fork
      cmd(3'b100, 13'h0020, 16'hbeef, 2'b00);
      begin
        repeat (8) @(posedge core_clk);
        #2 contend = 1'b0;
      end
    join
    cmd(3'b000, 13'h0020, 16'h0000, 2'b00);
    chk("stalled write", 16'hbeef, rsp_rdata);
  endtask
  // ==========
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {rst, req_valid, req_write, req_sem, req_oe_low_write} = 5'h10;
    {req_addr, req_wdata, req_lanes_n} = '0;
    {contend, other_owns} = {1'b0, 8'h20};
    repeat (4) @(posedge core_clk);
    #2 rst = 1'b0;
    chk("reset pins", 16'h01fd, {6'h00, rsp_valid, mem_oe_n, upper_lane_n,
      lower_lane_n, mem_ce_n, mem_sem_n, mem_rw_n, mem_data_oe_n,
      token_held, req_ready});
    chk("reset addr", 16'h0000, {3'h0, mem_addr});
    t_array();
    t_token();
    t_busy();
    wrap_up();
  end
endmodule
bind dp_port_host dp_port_monitor mon (.core_clk, .rst, .mem_addr,
  .mem_ce_n, .mem_sem_n, .mem_rw_n, .mem_oe_n, .mem_data_oe_n, .mem_busy_n);
`default_nettype wire
